// ### logic/dpi_pkg.sv
// constants and types for the sdram pin interface model
package dpi_pkg;
  localparam int DPI_ROW_W = 18;
  localparam int DPI_BG_W = 2;
  localparam int DPI_BA_W = 2;
  localparam int DPI_CID_W = 3;
  localparam int DPI_DQ_W = 8;
  localparam int DPI_A10_POS = 10;
  localparam int DPI_A12_POS = 12;
  localparam int DPI_A14_POS = 14;
  localparam int DPI_A15_POS = 15;
  localparam int DPI_A16_POS = 16;
  localparam int DPI_BURST_FULL = 8;
  localparam int DPI_BURST_CHOP = 4;
  localparam int DPI_CRC_BEATS = 2;
  localparam logic [7:0] DPI_CRC_INIT = 8'hFF;
  // decoded command kinds, a subset of the standard command table
  typedef enum logic [2:0] {
    DPI_CMD_NOP = 3'b000,
    DPI_CMD_ACT = 3'b001,
    DPI_CMD_RD = 3'b010,
    DPI_CMD_WR = 3'b011,
    DPI_CMD_PRE = 3'b100,
    DPI_CMD_MRS = 3'b101,
    DPI_CMD_OTHER = 3'b110
  } dpi_cmd_t;
  typedef enum logic [1:0] {
    DPI_ST_IDLE = 2'b00,
    DPI_ST_WDATA = 2'b01,
    DPI_ST_RDATA = 2'b10,
    DPI_ST_CRC = 2'b11
  } dpi_state_t;
endpackage

// ### logic/dpi_core.sv
// command decode, data path and termination control of one sdram byte lane
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dpi_core
  import dpi_pkg::*;
#(
  parameter int X16 = 0,                           // 1: x16 part
  parameter int X4 = 0                             // 1: x4 part, a17 valid
) (
  input wire logic clk_sys,                        // system clock
  input wire logic arst_n,                         // reset pin, active low
  input wire logic ck_t,                           // sdram clock true
  input wire logic ck_c,                           // sdram clock complement
  input wire logic cs_n,                           // chip select
  input wire logic act_n,                          // activate
  input wire logic [DPI_CID_W-1:0] cid,            // chip id, unused here
  input wire logic [DPI_BG_W-1:0] bg,              // bank group
  input wire logic [DPI_BA_W-1:0] ba,              // bank address
  input wire logic [DPI_ROW_W-1:0] addr,           // address, a16..a14 muxed
  input wire logic odt,                            // termination request
  input wire logic rtt_nom_en,                     // mr1 nominal termination on
  input wire logic tdqs_en,                        // mr1 a11
  input wire logic crc_en,                         // crc append enabled
  input wire logic dbi_en,                         // data bus inversion enabled
  input wire logic vref_mon,                       // mr4 a4 test mode
  input wire logic vref_lvl,                       // internal reference level
  input wire logic [DPI_DQ_W-1:0] dq_i,            // data pins in
  input wire logic dm_dbi_n_i,                     // mask/dbi pin in
  input wire logic [DPI_DQ_W-1:0] rd_data,         // core read data
  output logic [DPI_DQ_W-1:0] dq_o,                // data pins out
  output logic dq_oe,                              // data pins drive
  output logic dqs_t_o,                            // strobe true out
  output logic dqs_c_o,                            // strobe complement out
  output logic dqs_oe,                             // strobe drive
  output logic dm_dbi_n_o,                         // dbi pin out
  output logic dm_dbi_n_oe,                        // dbi pin drive
  output logic term_dq,                            // rtt on dq and strobes
  output logic term_dm,                            // rtt on mask lines
  output logic term_tdqs_c,                        // rtt on tdqs_c
  output logic [2:0] cmd,                          // decoded command
  output logic [DPI_BG_W-1:0] cmd_bg,              // latched bank group
  output logic [DPI_BA_W-1:0] cmd_ba,              // latched bank
  output logic [DPI_ROW_W-1:0] cmd_addr,           // row, column or opcode
  output logic cmd_vld,                            // one pulse per command arriving in DPI_ST_IDLE
  output logic auto_pre,                           // auto-precharge requested
  output logic pre_all,                            // precharge all banks
  output logic chop,                               // burst chopped
  output logic [DPI_DQ_W-1:0] wr_data,             // accepted write byte
  output logic wr_vld,                             // write byte pulse
  output logic [7:0] crc_out                       // crc of last burst
);
  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  localparam int SW = 2 + 1 + 1 + DPI_BG_W + DPI_BA_W + DPI_ROW_W + 1 + DPI_DQ_W + 1;
  logic [SW-1:0] sync1, sync2;
  logic ck_d;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      ck_d <= 1'b0;
    end else begin
      sync1 <= {ck_t, ck_c, cs_n, act_n, bg, ba, addr, odt, dq_i, dm_dbi_n_i};
      sync2 <= sync1;
      ck_d <= sync2[SW-1];
    end
  end
  wire logic s_ckt = sync2[SW-1];
  wire logic s_ckc = sync2[SW-2];
  wire logic s_cs_n = sync2[SW-3];
  wire logic s_act_n = sync2[SW-4];
  wire logic [DPI_BG_W-1:0] s_bg = sync2[SW-5 -: DPI_BG_W];
  wire logic [DPI_BA_W-1:0] s_ba = sync2[SW-5-DPI_BG_W -: DPI_BA_W];
  wire logic [DPI_ROW_W-1:0] s_addr = sync2[SW-5-DPI_BG_W-DPI_BA_W -: DPI_ROW_W];
  wire logic s_odt = sync2[DPI_DQ_W+1];
  wire logic [DPI_DQ_W-1:0] s_dq = sync2[DPI_DQ_W:1];
  wire logic s_dm = sync2[0];
  // true rises while complement is low: the crossing
  wire logic ck_edge = s_ckt & ~ck_d & ~s_ckc;
  wire logic ck_fall = ~s_ckt & ck_d;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  function automatic dpi_cmd_t decode(input logic c, input logic a, input logic r,
                                      input logic k, input logic w);
    dpi_cmd_t v;
    v = DPI_CMD_NOP;
    if (c) v = DPI_CMD_NOP;
    else if (!a) v = DPI_CMD_ACT;
    else begin
      case ({r, k, w})
        3'b101: v = DPI_CMD_RD;
        3'b100: v = DPI_CMD_WR;
        3'b010: v = DPI_CMD_PRE;
        3'b000: v = DPI_CMD_MRS;
        3'b111: v = DPI_CMD_NOP;
        default: v = DPI_CMD_OTHER;
      endcase
    end
    return v;
  endfunction

  dpi_state_t state, next_state;
  logic [3:0] beat, next_beat;
  logic [3:0] blen, next_blen;
  logic [2:0] next_cmd;
  logic [DPI_BG_W-1:0] next_cmd_bg;
  logic [DPI_BA_W-1:0] next_cmd_ba;
  logic [DPI_ROW_W-1:0] next_cmd_addr;
  logic next_cmd_vld, next_auto_pre, next_pre_all, next_chop;
  logic [DPI_DQ_W-1:0] next_wr_data, next_dq_o;
  logic next_wr_vld, next_dq_oe, next_dqs_t, next_dqs_oe, next_dbi_o;
  logic [7:0] crc, next_crc, next_crc_out;
  dpi_cmd_t dc;
  logic [DPI_DQ_W-1:0] wbyte, rbyte;
  logic rinv;

  always_comb begin
    dc = decode(s_cs_n, s_act_n, s_addr[DPI_A16_POS], s_addr[DPI_A15_POS],
                s_addr[DPI_A14_POS]);
    next_state = state;
    next_beat = beat;
    next_blen = blen;
    next_cmd = cmd;
    next_cmd_bg = cmd_bg;
    next_cmd_ba = cmd_ba;
    next_cmd_addr = cmd_addr;
    next_cmd_vld = 1'b0;
    next_auto_pre = auto_pre;
    next_pre_all = pre_all;
    next_chop = chop;
    next_wr_data = wr_data;
    next_wr_vld = 1'b0;
    next_dq_o = dq_o;
    next_dq_oe = dq_oe;
    next_dqs_t = dqs_t_o;
    next_dqs_oe = dqs_oe;
    next_dbi_o = dm_dbi_n_o;
    next_crc = crc;
    next_crc_out = crc_out;
    // dbi and mask share one pin; dbi wins when enabled
    wbyte = (dbi_en && !s_dm) ? ~s_dq : s_dq;
    rinv = dbi_en && ($countones(rd_data) > DPI_DQ_W / 2);
    rbyte = rinv ? ~rd_data : rd_data;
    if (ck_edge) begin
      case (state)
        DPI_ST_IDLE: begin
          if (dc != DPI_CMD_NOP) begin
            next_cmd = dc;
            next_cmd_vld = 1'b1;
            next_cmd_bg = (X16 != 0) ? {1'b0, s_bg[0]} : s_bg;
            next_cmd_ba = s_ba;
            next_cmd_addr = s_addr;
            if (X4 == 0) next_cmd_addr[DPI_ROW_W-1] = 1'b0;
            if (dc != DPI_CMD_ACT) begin
              next_cmd_addr[DPI_A16_POS] = 1'b0;
              next_cmd_addr[DPI_A15_POS] = 1'b0;
              next_cmd_addr[DPI_A14_POS] = 1'b0;
            end
            next_pre_all = (dc == DPI_CMD_PRE) && s_addr[DPI_A10_POS];
            next_auto_pre = (dc == DPI_CMD_RD || dc == DPI_CMD_WR) &&
                            s_addr[DPI_A10_POS];
            next_chop = (dc == DPI_CMD_RD || dc == DPI_CMD_WR) &&
                        !s_addr[DPI_A12_POS];
            next_blen = s_addr[DPI_A12_POS] ? 4'(DPI_BURST_FULL) : 4'(DPI_BURST_CHOP);
            next_beat = 4'h0;
            next_crc = DPI_CRC_INIT;
            if (dc == DPI_CMD_WR) next_state = DPI_ST_WDATA;
            if (dc == DPI_CMD_RD) begin
              next_state = DPI_ST_RDATA;
              next_dq_oe = 1'b1;
              next_dqs_oe = 1'b1;
            end
          end
        end
        DPI_ST_WDATA: begin
          // mask only when dbi is off: the pin carries one function
          if (dbi_en || s_dm) begin
            next_wr_data = wbyte;
            next_wr_vld = 1'b1;
          end
          next_crc = crc ^ wbyte;
          next_beat = beat + 4'h1;
          if (beat + 4'h1 == blen) begin
            next_beat = 4'h0;
            next_crc_out = crc ^ wbyte;
            next_state = crc_en ? DPI_ST_CRC : DPI_ST_IDLE;
          end
        end
        DPI_ST_RDATA: begin
          next_dq_o = rbyte;
          next_dbi_o = ~rinv;
          next_dqs_t = 1'b1;
          next_crc = crc ^ rbyte;
          next_beat = beat + 4'h1;
          if (beat + 4'h1 == blen) begin
            next_beat = 4'h0;
            next_crc_out = crc ^ rbyte;
            next_state = crc_en ? DPI_ST_CRC : DPI_ST_IDLE;
          end
        end
        DPI_ST_CRC: begin
          // simple xor code stands in for the burst crc
          if (dq_oe) next_dq_o = (beat == 4'h0) ? crc_out : ~crc_out;
          next_dqs_t = dqs_oe;
          next_beat = beat + 4'h1;
          if (beat + 4'h1 == 4'(DPI_CRC_BEATS)) next_state = DPI_ST_IDLE;
        end
        default: next_state = DPI_ST_IDLE;
      endcase
    end else if (ck_fall && state != DPI_ST_IDLE) begin
      next_dqs_t = 1'b0;
    end else if (ck_fall && dqs_oe) begin
      // release only after the last beat had its full high phase
      next_dqs_t = 1'b0;
      next_dq_oe = 1'b0;
      next_dqs_oe = 1'b0;
    end
    // reference level shown on dq0 while the test mode is set
    if (vref_mon) begin
      next_dq_o[0] = vref_lvl;
      next_dq_oe = 1'b1;
    end else if (state == DPI_ST_IDLE && !ck_edge && !dqs_oe) begin
      next_dq_oe = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // termination
  // --------------------------------------------------------------------------
  logic next_term;
  always_comb begin
    next_term = s_odt && rtt_nom_en && !dq_oe;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= DPI_ST_IDLE;
      beat <= 4'h0;
      blen <= 4'h0;
      cmd <= DPI_CMD_NOP;
      cmd_bg <= '0;
      cmd_ba <= '0;
      cmd_addr <= '0;
      cmd_vld <= 1'b0;
      auto_pre <= 1'b0;
      pre_all <= 1'b0;
      chop <= 1'b0;
      wr_data <= '0;
      wr_vld <= 1'b0;
      dq_o <= '0;
      dq_oe <= 1'b0;
      dqs_t_o <= 1'b0;
      dqs_c_o <= 1'b1;
      dqs_oe <= 1'b0;
      dm_dbi_n_o <= 1'b1;
      dm_dbi_n_oe <= 1'b0;
      crc <= DPI_CRC_INIT;
      crc_out <= 8'h00;
      term_dq <= 1'b0;
      term_dm <= 1'b0;
      term_tdqs_c <= 1'b0;
    end else begin
      state <= next_state;
      beat <= next_beat;
      blen <= next_blen;
      cmd <= next_cmd;
      cmd_bg <= next_cmd_bg;
      cmd_ba <= next_cmd_ba;
      cmd_addr <= next_cmd_addr;
      cmd_vld <= next_cmd_vld;
      auto_pre <= next_auto_pre;
      pre_all <= next_pre_all;
      chop <= next_chop;
      wr_data <= next_wr_data;
      wr_vld <= next_wr_vld;
      dq_o <= next_dq_o;
      dq_oe <= next_dq_oe;
      dqs_t_o <= next_dqs_t;
      dqs_c_o <= ~next_dqs_t;
      dqs_oe <= next_dqs_oe;
      dm_dbi_n_o <= next_dbi_o;
      dm_dbi_n_oe <= next_dqs_oe && dbi_en;
      crc <= next_crc;
      crc_out <= next_crc_out;
      term_dq <= next_term;
      term_dm <= next_term;
      term_tdqs_c <= next_term && tdqs_en && (X16 == 0);
    end
  end
  // chip id carries no function on this module
  wire logic unused_cid = ^cid;
endmodule // dpi_core
`default_nettype wire

// ### tb/dpi_core_props.sv
// assertion checker for the sdram pin interface core
`timescale 1ns/1ps
`default_nettype none
module dpi_core_props
  import dpi_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // reset
  input wire logic odt, // termination request
  input wire logic rtt_nom_en, // nominal termination on
  input wire logic tdqs_en, // tdqs enable
  input wire logic dq_oe, // data drive
  input wire logic dqs_t_o, // strobe true
  input wire logic dqs_c_o, // strobe complement
  input wire logic term_dq, // dq termination
  input wire logic term_dm, // mask termination
  input wire logic term_tdqs_c, // tdqs_c termination
  input wire logic [2:0] cmd, // decoded command
  input wire logic [DPI_ROW_W-1:0] cmd_addr, // latched address
  input wire logic cmd_vld, // command pulse
  input wire logic auto_pre, // auto-precharge
  input wire logic pre_all, // precharge all
  input wire logic chop, // burst chop
  input wire logic wr_vld // write byte pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_term_on: assert property ((odt && rtt_nom_en && !dq_oe)[*5] |-> term_dq && term_dm)
    else $error("termination missing with odt high");
  chk_tdqs_gate: assert property (!tdqs_en && !$past(tdqs_en) |-> !term_tdqs_c)
    else $error("tdqs_c terminated while tdqs off");
  chk_odt_ignored: assert property (!rtt_nom_en && !$past(rtt_nom_en) |-> !term_dq && !term_dm)
    else $error("termination on while disabled");
  chk_cmd_hold: assert property (!cmd_vld |-> $stable(cmd) && $stable(cmd_addr))
    else $error("command fields moved without a command");
  chk_vld_pulse: assert property (cmd_vld |=> !cmd_vld)
    else $error("command pulse longer than one cycle");
  chk_pre_all: assert property (cmd_vld && cmd == DPI_CMD_PRE |-> pre_all == cmd_addr[DPI_A10_POS])
    else $error("precharge scope wrong");
  chk_auto_pre: assert property (cmd_vld && cmd inside {DPI_CMD_RD, DPI_CMD_WR} |->
    auto_pre == cmd_addr[DPI_A10_POS])
    else $error("auto-precharge wrong");
  chk_burst_chop: assert property (cmd_vld && cmd inside {DPI_CMD_RD, DPI_CMD_WR} |->
    chop == !cmd_addr[DPI_A12_POS])
    else $error("burst chop wrong");
  chk_strobe_pair: assert property (dqs_c_o == !dqs_t_o)
    else $error("strobe pair not complementary");
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0) !arst_n |->
    !cmd_vld && !wr_vld && !dq_oe && dqs_c_o)
    else $error("outputs active in reset");
endmodule // dpi_core_props
bind dpi_core dpi_core_props i_props (.clk_sys(clk_sys), .arst_n(arst_n), .odt(odt),
  .rtt_nom_en(rtt_nom_en), .tdqs_en(tdqs_en), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o),
  .dqs_c_o(dqs_c_o), .term_dq(term_dq), .term_dm(term_dm), .term_tdqs_c(term_tdqs_c),
  .cmd(cmd), .cmd_addr(cmd_addr), .cmd_vld(cmd_vld), .auto_pre(auto_pre), .pre_all(pre_all),
  .chop(chop), .wr_vld(wr_vld));
`default_nettype wire

// ### tb/dpi_host_model.sv
// host controller model: sdram clock, command and write data pins
`timescale 1ns/1ps
`default_nettype none
module dpi_host_model
  import dpi_pkg::*;
(
  input wire logic clk_sys, // system clock
  output logic ck_t, // sdram clock true
  output logic ck_c, // sdram clock complement
  output logic cs_n, // chip select
  output logic act_n, // activate
  output logic [DPI_BG_W-1:0] bg, // bank group
  output logic [DPI_BA_W-1:0] ba, // bank address
  output logic [DPI_ROW_W-1:0] addr, // address
  output logic [DPI_DQ_W-1:0] dq_i, // write data
  output logic dm_dbi_n_i // mask or inversion
);
  logic run;
  assign ck_c = run ? ~ck_t : 1'h1;
  // clock stands low between frames; odd offset keeps edges off clk_sys edges
  initial begin
    {ck_t, run, act_n, cs_n, dm_dbi_n_i} = 5'h07;
    {addr, bg, ba, dq_i} = '0;
    #3;
    forever begin
      #62.5;
      ck_t = run ? ~ck_t : 1'h0;
    end
  end
  task automatic issue(input logic c, input logic a_n, input logic [DPI_ROW_W-1:0] a,
    input logic [1:0] g, input logic [1:0] b, input int n, input logic [7:0] m);
    logic wr;
    wr = a_n && a[DPI_A16_POS-:3] == 3'h4;
    @(negedge clk_sys);
    run = 1'h1;
    cs_n = c;
    act_n = a_n;
    addr = a;
    bg = g;
    ba = b;
    for (int i = 0; i <= n; i++) begin
      @(posedge ck_t);
      @(negedge ck_t);
      @(negedge clk_sys);
      cs_n = 1'h1;
      addr = ~addr;
      // released address, data and mask lines flip each beat rather than keep the last value
      dq_i = (wr && i < n) ? 8'hA0 + i[7:0] : ~dq_i;
      dm_dbi_n_i = (wr && i < n) ? ~m[i] : ~dm_dbi_n_i;
    end
    run = 1'h0;
  endtask
endmodule // dpi_host_model
`default_nettype wire

// ### tb/test_dpi_core.sv
// self-checking bench for the sdram pin interface core
`timescale 1ns/1ps
`default_nettype none
module test_dpi_core
  import dpi_pkg::*;
();
  typedef struct packed {
    logic act; logic [17:0] a; logic [1:0] g; logic [1:0] b; logic [3:0] n; logic [7:0] m;
    logic [2:0] c; logic ap; logic pa; logic ch;
  } dpi_tb_row_t;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h1;
  logic ck_t, ck_c, cs_n, act_n, odt, rtt_nom_en, tdqs_en, crc_en, dbi_en, dm_dbi_n_i;
  logic [1:0] bg, ba, cmd_bg, cmd_ba;
  logic [17:0] addr, cmd_addr;
  logic [7:0] dq_i, dq_o, wr_data, crc_out;
  logic [2:0] cmd;
  logic dq_oe, dqs_t_o, dqs_c_o, dqs_oe, dm_dbi_n_o, dm_dbi_n_oe, term_dq, term_dm, term_tdqs_c;
  logic cmd_vld, auto_pre, pre_all, chop, wr_vld, rd_seen;
  logic vref_mon, vref_lvl, dqs_q, rd_dbi_exp;
  logic [7:0] rd_data, rd_exp;
  int rd_beats = 0;
  int rd_good = 0;
  int miscompares = 0;
  int total_checks = 0;
  int vld_cnt = 0;
  logic [7:0] wr_q[$];
  dpi_tb_row_t rows [8] = '{
    '{1'h0, 18'h3C005, 2'h2, 2'h1, 4'h0, 8'h00, 3'h1, 1'h0, 1'h0, 1'h0},
    '{1'h1, 18'h11400, 2'h1, 2'h2, 4'h8, 8'h04, 3'h3, 1'h1, 1'h0, 1'h0},
    '{1'h1, 18'h10000, 2'h0, 2'h3, 4'h4, 8'h00, 3'h3, 1'h0, 1'h0, 1'h1},
    '{1'h1, 18'h15000, 2'h3, 2'h0, 4'h8, 8'h00, 3'h2, 1'h0, 1'h0, 1'h0},
    '{1'h1, 18'h08000, 2'h1, 2'h1, 4'h0, 8'h00, 3'h4, 1'h0, 1'h0, 1'h0},
    '{1'h1, 18'h08400, 2'h2, 2'h0, 4'h0, 8'h00, 3'h4, 1'h0, 1'h1, 1'h0},
    '{1'h1, 18'h00123, 2'h1, 2'h3, 4'h0, 8'h00, 3'h5, 1'h0, 1'h0, 1'h0},
    '{1'h1, 18'h04000, 2'h0, 2'h2, 4'h0, 8'h00, 3'h6, 1'h0, 1'h0, 1'h0}};
  always #5 clk_sys = ~clk_sys;
  dpi_host_model i_host (.clk_sys(clk_sys), .ck_t(ck_t), .ck_c(ck_c), .cs_n(cs_n),
    .act_n(act_n), .bg(bg), .ba(ba), .addr(addr), .dq_i(dq_i), .dm_dbi_n_i(dm_dbi_n_i));
  dpi_core i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ck_t(ck_t), .ck_c(ck_c), .cs_n(cs_n),
    .act_n(act_n), .cid(3'h0), .bg(bg), .ba(ba), .addr(addr), .odt(odt),
    .rtt_nom_en(rtt_nom_en), .tdqs_en(tdqs_en), .crc_en(crc_en), .dbi_en(dbi_en),
    .vref_mon(vref_mon), .vref_lvl(vref_lvl), .dq_i(dq_i), .dm_dbi_n_i(dm_dbi_n_i),
    .rd_data(rd_data),
    .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe),
    .dm_dbi_n_o(dm_dbi_n_o), .dm_dbi_n_oe(dm_dbi_n_oe), .term_dq(term_dq), .term_dm(term_dm),
    .term_tdqs_c(term_tdqs_c), .cmd(cmd), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
    .cmd_addr(cmd_addr), .cmd_vld(cmd_vld), .auto_pre(auto_pre), .pre_all(pre_all),
    .chop(chop), .wr_data(wr_data), .wr_vld(wr_vld), .crc_out(crc_out));
  always @(negedge clk_sys) begin
    if (cmd_vld === 1'h1) vld_cnt++;
    if (wr_vld === 1'h1) wr_q.push_back(wr_data);
    if (dq_oe === 1'h1 && dqs_oe === 1'h1) rd_seen = 1'h1;
    // one beat per strobe rise; byte, inversion flag and its drive must match
    if (dqs_t_o === 1'h1 && dqs_q !== 1'h1) begin
      rd_beats++;
      if (dq_o === rd_exp && dm_dbi_n_o === rd_dbi_exp && dm_dbi_n_oe === dbi_en) rd_good++;
    end
    dqs_q = dqs_t_o;
  end
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    {odt, rtt_nom_en, tdqs_en, crc_en, dbi_en, rd_seen} = 6'h00;
    {vref_mon, vref_lvl, rd_dbi_exp} = 3'h1;
    rd_data = 8'h5A;
    rd_exp = 8'h5A;
    // start high so the reset gets a real falling edge
    #1 arst_n = 1'h0;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      i_host.issue(1'h0, rows[i].act, rows[i].a, rows[i].g, rows[i].b, rows[i].n, rows[i].m);
      repeat (5) @(posedge clk_sys);
      chk("cmd count", 18'(vld_cnt), 18'(i + 1));
      chk("cmd", cmd, rows[i].c);
      chk("cmd_addr", cmd_addr, rows[i].a & (rows[i].act ? 18'h03FFF : 18'h1FFFF));
      chk("cmd_bg", cmd_bg, rows[i].g);
      chk("cmd_ba", cmd_ba, rows[i].b);
      if (rows[i].c == DPI_CMD_PRE) chk("pre_all", pre_all, rows[i].pa);
      if (rows[i].c inside {DPI_CMD_RD, DPI_CMD_WR}) begin
        chk("auto_pre", auto_pre, rows[i].ap);
        chk("chop", chop, rows[i].ch);
      end
      if (rows[i].c == DPI_CMD_WR)
        for (int k = 0; k < rows[i].n; k++)
          if (!rows[i].m[k]) chk("wr_data", wr_q.pop_front(), 18'(8'hA0 + k));
      chk("wr count", 18'(wr_q.size()), 18'h0);
    end
    chk("read drive", rd_seen, 1'h1);
    chk("read beats", 18'(rd_beats), 18'h8);
    chk("read bytes", 18'(rd_good), 18'h8);
    // a deselected read must not add a command pulse
    i_host.issue(1'h1, 1'h1, 18'h15000, 2'h0, 2'h0, 8, 8'h00);
    repeat (5) @(posedge clk_sys);
    chk("ignored cmd", 18'(vld_cnt), 18'h8);
    // inversion plus crc: the two trailing crc beats are not data
    @(negedge clk_sys);
    {dbi_en, crc_en} = 2'h3;
    i_host.issue(1'h0, 1'h1, 18'h10000, 2'h0, 2'h0, 6, 8'h02);
    repeat (5) @(posedge clk_sys);
    foreach (rows[k])
      if (k < 4) chk("dbi data", wr_q.pop_front(), k == 1 ? 18'h5E : 18'(8'hA0 + k));
    chk("crc beats", 18'(wr_q.size()), 18'h0);
    chk("crc_out", crc_out, 18'h00);
    // read with inversion: seven ones go out inverted, two strobed crc beats follow
    @(negedge clk_sys);
    rd_data = 8'hF7;
    rd_exp = 8'h08;
    rd_dbi_exp = 1'h0;
    i_host.issue(1'h0, 1'h1, 18'h15000, 2'h0, 2'h0, 10, 8'h00);
    repeat (5) @(posedge clk_sys);
    chk("dbi read beats", 18'(rd_beats), 18'h12);
    chk("dbi read bytes", 18'(rd_good), 18'h10);
    chk("read crc_out", crc_out, 18'hFF);
    @(negedge clk_sys);
    {odt, rtt_nom_en, tdqs_en} = 3'h7;
    repeat (10) @(negedge clk_sys);
    chk("term_dq", term_dq, 1'h1);
    chk("term_tdqs_c", term_tdqs_c, 1'h1);
    chk("term_dm", term_dm, 1'h1);
    tdqs_en = 1'h0;
    repeat (4) @(negedge clk_sys);
    chk("term_tdqs_c off", term_tdqs_c, 1'h0);
    chk("term_dq kept", term_dq, 1'h1);
    rtt_nom_en = 1'h0;
    repeat (10) @(negedge clk_sys);
    chk("term_dq off", term_dq, 1'h0);
    // reference level test mode drives dq0
    vref_mon = 1'h1;
    vref_lvl = 1'h1;
    repeat (3) @(negedge clk_sys);
    chk("vref drive", dq_oe, 1'h1);
    chk("vref level", dq_o[0], 1'h1);
    vref_mon = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk("vref release", dq_oe, 1'h0);
    arst_n = 1'h0;
    @(negedge clk_sys);
    chk("cmd in reset", cmd, 3'h0);
    chk("dqs_c_o in reset", dqs_c_o, 1'h1);
    arst_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    complete_run();
  end
endmodule // test_dpi_core
`default_nettype wire
